// >>> vra_pkg.sv
package vra_pkg;
    // register indices on the host bus
    localparam logic [4:0] REG_HTOTAL = 5'h00;
    localparam logic [4:0] REG_HDISP = 5'h01;
    localparam logic [4:0] REG_HSPOS = 5'h02;
    localparam logic [4:0] REG_SWIDTH = 5'h03;
    localparam logic [4:0] REG_VTOTAL = 5'h04;
    localparam logic [4:0] REG_VDISP = 5'h06;
    localparam logic [4:0] REG_VSPOS = 5'h07;
    localparam logic [4:0] REG_MODE = 5'h08;
    localparam logic [4:0] REG_MAXSL = 5'h09;
    localparam logic [4:0] REG_START_HI = 5'h0c;
    localparam logic [4:0] REG_START_LO = 5'h0d;
    localparam logic [4:0] REG_UPD_HI = 5'h12;
    localparam logic [4:0] REG_UPD_LO = 5'h13;
    localparam logic [4:0] REG_DUMMY = 5'h1f;
    // mode control field positions
    localparam int MODE_ILACE = 0;
    localparam int MODE_VIDEO = 1;
    localparam int MODE_ROWCOL = 2;
    localparam int MODE_TRANSP = 3;
    localparam int MODE_BLANK_UPD = 7;
    // status field position
    localparam int STAT_VBLANK = 5;
    // reset values of the timing registers
    localparam logic [7:0] RST_HTOTAL = 8'h3f;
    localparam logic [7:0] RST_HDISP = 8'h28;
    localparam logic [7:0] RST_HSPOS = 8'h30;
    localparam logic [7:0] RST_SWIDTH = 8'h24;
    localparam logic [6:0] RST_VTOTAL = 7'h1f;
    localparam logic [6:0] RST_VDISP = 7'h19;
    localparam logic [6:0] RST_VSPOS = 7'h1c;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [4:0] RST_MAXSL = 5'h07;
    // row/column layout puts each row 256 locations further on
    localparam logic [13:0] ROWCOL_STEP = 14'h0100;
    // host bus phase counter: e high in the last two of four cycles
    localparam logic [1:0] PH_LAST = 2'h3;
endpackage : vra_pkg

// >>> vra_if.sv
`timescale 1ns/100ps
interface vra_if;
    logic e; // phase 2 enable from the host
    logic cs_n; // chip select, active low
    logic rs; // 0 address/status, 1 data register
    logic rw; // 1 read, 0 write
    logic [7:0] dbus_h2d; // host write data
    logic [7:0] dbus_d2h; // device read data
    logic dbus_oe_n; // low while the device drives the data bus
    logic [13:0] display_address_lines; // refresh or update address
    logic [4:0] ra; // scan line; bit 4 may carry the update pulse
    logic hsync;
    logic vsync;
    logic de; // display enable
    modport dev (input e, cs_n, rs, rw, dbus_h2d,
        output dbus_d2h, dbus_oe_n, display_address_lines, ra, hsync, vsync, de);
    modport host (output e, cs_n, rs, rw, dbus_h2d,
        input dbus_d2h, dbus_oe_n, display_address_lines, ra, hsync, vsync, de);
endinterface : vra_if

// >>> vra_dev.sv
// Operation
// R1 - unimplemented readable bits return zero
// R2 - dummy location or deselect: bus undriven
// R3 - binary mode: rows step by displayed count
// R4 - row/column mode: rows step by 256
// R5 - transparent mode: device alone drives addresses
// R6 - priority mode: host address overrides refresh
// R7 - interleave: refresh in phase 1, host phase 2
// R8 - status bit 5 high during vertical blanking
// R9 - transparent interleave: update address in phase 2
// R10 - host loads update address before access
// R11 - blanking update only inside blanking intervals
// R12 - update pulse marks update address present
// R13 - external latches hold host write data
// R14 - non-interlace: identical fields, every line
// R15 - interlace: alternate even and odd fields
// R16 - interlace sync: vsync half line later
// R17 - sync and video: even/odd lines per field
// R18 - mode bit selects row/column or binary
// R19 - refresh addresses driven otherwise
`timescale 1ns/100ps
module vra_dev
    import vra_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    vra_if.dev bus
);
    // all state of the device
    typedef struct packed {
        logic [4:0] addr; // selected register index
        logic [7:0] htotal;
        logic [7:0] hdisp;
        logic [7:0] hspos;
        logic [7:0] swidth; // vsync width high nibble, hsync low
        logic [6:0] vtotal;
        logic [6:0] vdisp;
        logic [6:0] vspos;
        logic [7:0] mode;
        logic [4:0] maxsl;
        logic [13:0] start;
        logic [13:0] upd; // update address register
        logic [7:0] hcnt; // character count in line
        logic [4:0] sl; // scan line in row
        logic [6:0] row;
        logic [13:0] row_start;
        logic field; // 1 = odd field
        logic [4:0] hs_left;
        logic [4:0] vs_left;
        logic upd_pend; // update address waiting for blanking
        logic e_q; // previous e for edge finding
        logic [13:0] ma;
        logic [4:0] ra;
        logic hsync;
        logic vsync;
        logic de;
        logic [7:0] rdata;
    } vra_dev_s;

    vra_dev_s q;
    vra_dev_s d;

    // scratch terms
    logic wr; // register write taken this cycle
    logic line_end, sl_end, row_end, frame_end; // raster boundaries
    logic video; // interlaced sync and video
    logic hbl, vbl; // horizontal and vertical blanking
    logic grant; // update slot granted; update address shown from the next clock
    logic sl_first; // first scan line of a row in this field
    logic [7:0] vs_point; // character at which vsync counts
    logic [13:0] refresh, row_step;

    // host sees the bus undriven for the dummy slot and when deselected
    assign bus.dbus_oe_n = !(!bus.cs_n && bus.rw && bus.e
        && !(bus.rs && q.addr == REG_DUMMY)); // R2
    assign bus.dbus_d2h = q.rdata;
    assign bus.display_address_lines = q.ma; // R5
    assign bus.ra = q.ra;
    assign bus.hsync = q.hsync;
    assign bus.vsync = q.vsync;
    assign bus.de = q.de;

    // next state
    always_comb
    begin
        d = q;
        d.e_q = bus.e;
        // writes take effect on the rising edge of e
        wr = bus.e && !q.e_q && !bus.cs_n && !bus.rw;
        video = q.mode[MODE_ILACE] && q.mode[MODE_VIDEO];
        hbl = q.hcnt >= q.hdisp;
        vbl = q.row >= q.vdisp;

        // register writes, decoded by index
        if (wr && !bus.rs)
        begin
            d.addr = bus.dbus_h2d[4:0];
        end
        else if (wr)
        begin
            if (q.addr == REG_HTOTAL)
            begin
                d.htotal = bus.dbus_h2d;
            end
            else if (q.addr == REG_HDISP)
            begin
                d.hdisp = bus.dbus_h2d;
            end
            else if (q.addr == REG_HSPOS)
            begin
                d.hspos = bus.dbus_h2d;
            end
            else if (q.addr == REG_SWIDTH)
            begin
                d.swidth = bus.dbus_h2d;
            end
            else if (q.addr == REG_VTOTAL)
            begin
                d.vtotal = bus.dbus_h2d[6:0];
            end
            else if (q.addr == REG_VDISP)
            begin
                d.vdisp = bus.dbus_h2d[6:0];
            end
            else if (q.addr == REG_VSPOS)
            begin
                d.vspos = bus.dbus_h2d[6:0];
            end
            else if (q.addr == REG_MODE)
            begin
                d.mode = bus.dbus_h2d; // R18
            end
            else if (q.addr == REG_MAXSL)
            begin
                d.maxsl = bus.dbus_h2d[4:0];
            end
            else if (q.addr == REG_START_HI)
            begin
                d.start[13:8] = bus.dbus_h2d[5:0];
            end
            else if (q.addr == REG_START_LO)
            begin
                d.start[7:0] = bus.dbus_h2d;
            end
            else if (q.addr == REG_UPD_HI)
            begin
                d.upd[13:8] = bus.dbus_h2d[5:0]; // R10
            end
            else if (q.addr == REG_UPD_LO)
            begin
                d.upd[7:0] = bus.dbus_h2d; // R10
            end
        end

        // read data: only status has live bits, the rest read zero
        d.rdata = 8'h00; // R1
        if (!bus.rs)
        begin
            d.rdata[STAT_VBLANK] = vbl; // R8
        end

        // horizontal and vertical counting, same every field outside video mode
        line_end = q.hcnt == q.htotal; // R14
        sl_end = video ? (q.sl[4:1] >= q.maxsl[4:1]) : (q.sl >= q.maxsl);
        row_end = line_end && sl_end;
        frame_end = row_end && q.row == q.vtotal;
        d.hcnt = line_end ? 8'h00 : q.hcnt + 8'h01;
        row_step = q.mode[MODE_ROWCOL] ? ROWCOL_STEP : {6'h00, q.hdisp}; // R3 R4 R18
        if (frame_end)
        begin
            // interlace alternates fields; plain mode ignores the bit
            d.field = q.mode[MODE_ILACE] ? !q.field : 1'b0; // R15
            d.row = 7'h00;
            d.row_start = q.start;
            // video mode starts each field on its own line parity
            d.sl = video ? {4'h0, !q.field} : 5'h00; // R17
        end
        else if (row_end)
        begin
            d.row = q.row + 7'h01;
            d.row_start = q.row_start + row_step; // R3 R4
            d.sl = video ? {4'h0, q.field} : 5'h00; // R17
        end
        else if (line_end)
        begin
            // video mode skips the other field's lines
            d.sl = q.sl + (video ? 5'h02 : 5'h01); // R17
        end
        // refresh address for this character; row/column keeps the column in the low byte
        refresh = q.mode[MODE_ROWCOL] ? {q.row_start[13:8], q.row_start[7:0] + q.hcnt} // R4
            : q.row_start + {6'h00, q.hcnt}; // R3

        // horizontal sync, width 0 counts as 16
        if (q.hcnt == q.hspos)
        begin
            d.hs_left = {q.swidth[3:0] == 4'h0, q.swidth[3:0]};
        end
        else if (q.hs_left != 5'h00)
        begin
            d.hs_left = q.hs_left - 5'h01;
        end
        d.hsync = d.hs_left != 5'h00;

        // vertical sync: odd interlaced fields move half a line later
        vs_point = (q.mode[MODE_ILACE] && q.field) ? {1'b0, q.htotal[7:1]} : 8'h00; // R16
        sl_first = q.sl == (video ? {4'h0, q.field} : 5'h00);
        if (q.hcnt == vs_point)
        begin
            if (q.row == q.vspos && sl_first)
            begin
                d.vs_left = {q.swidth[7:4] == 4'h0, q.swidth[7:4]}; // R16
            end
            else if (q.vs_left != 5'h00)
            begin
                d.vs_left = q.vs_left - 5'h01;
            end
        end
        d.vsync = d.vs_left != 5'h00;

        // blanking update: one character slot per pending write
        grant = q.mode[MODE_TRANSP] && q.mode[MODE_BLANK_UPD] && q.upd_pend
            && (hbl || vbl); // R11
        // a new write in the grant cycle keeps the request alive
        d.upd_pend = (wr && bus.rs && q.addr == REG_UPD_LO) || (q.upd_pend && !grant);
        // address mux; the result lags e by one clock
        if (q.mode[MODE_TRANSP] && !q.mode[MODE_BLANK_UPD] && bus.e)
        begin
            d.ma = q.upd; // R9
        end
        else if (grant)
        begin
            d.ma = q.upd; // R11
        end
        else
        begin
            d.ma = refresh; // R19 R9
        end

        // scan line bit 4 doubles as update pulse in blanking update mode
        if (q.mode[MODE_TRANSP] && q.mode[MODE_BLANK_UPD])
        begin
            d.ra = {grant, q.sl[3:0]}; // R12
        end
        else
        begin
            d.ra = q.sl;
        end
        d.de = !hbl && !vbl;
    end

    // state register
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            q <= '0;
            q.htotal <= RST_HTOTAL;
            q.hdisp <= RST_HDISP;
            q.hspos <= RST_HSPOS;
            q.swidth <= RST_SWIDTH;
            q.vtotal <= RST_VTOTAL;
            q.vdisp <= RST_VDISP;
            q.vspos <= RST_VSPOS;
            q.mode <= RST_MODE;
            q.maxsl <= RST_MAXSL;
        end
        else
        begin
            q <= d;
        end
    end
endmodule : vra_dev

// >>> vra_host.sv
`timescale 1ns/100ps
module vra_host
    import vra_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    vra_if.host bus,
    input wire logic I_REQ, // register access request
    input wire logic I_WR, // 1 write, 0 read
    input wire logic I_RS, // register select
    input wire logic [7:0] I_WDATA,
    output logic O_READY, // request taken when high with I_REQ
    output logic [7:0] O_RDATA,
    output logic O_DONE, // one-cycle pulse at end of bus cycle
    input wire logic I_TRANSPARENT, // memory behind the device
    input wire logic I_INTERLEAVE, // shared: phase interleave, else priority
    input wire logic I_MPU_ACC, // shared priority access request
    input wire logic [13:0] I_MPU_ADDR,
    input wire logic I_HOLD_LOAD, // capture write data into hold latch
    input wire logic [7:0] I_HOLD_DATA,
    output logic [13:0] O_MEM_ADDR,
    output logic [7:0] O_MEM_DATA,
    output logic O_MEM_WE // pulse: latched data written at update slot
);
    // one-hot bus cycle states
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010, // waiting for a phase boundary
        ST_CYC = 3'b100
    } vra_host_st_e;

    // all state of the host end
    typedef struct packed {
        vra_host_st_e st;
        logic [1:0] ph; // free running phase count, e = ph[1]
        logic cs_n;
        logic rs;
        logic rw;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic done;
        logic [13:0] mem_addr;
        logic [7:0] hold;
        logic hold_full;
        logic mem_we;
    } vra_host_s;

    vra_host_s q;
    vra_host_s d;

    assign bus.e = q.ph[1];
    assign bus.cs_n = q.cs_n;
    assign bus.rs = q.rs;
    assign bus.rw = q.rw;
    assign bus.dbus_h2d = q.wdata;
    assign O_READY = q.st == ST_IDLE;
    assign O_RDATA = q.rdata;
    assign O_DONE = q.done;
    assign O_MEM_ADDR = q.mem_addr;
    assign O_MEM_DATA = q.hold;
    assign O_MEM_WE = q.mem_we;

    // next state
    always_comb
    begin
        d = q;
        d.ph = q.ph + 2'h1;
        d.done = 1'b0;
        case (q.st)
            ST_IDLE:
            begin
                if (I_REQ)
                begin
                    d.rs = I_RS;
                    d.rw = !I_WR;
                    d.wdata = I_WDATA;
                    d.st = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                // select for a whole e period
                if (q.ph == PH_LAST)
                begin
                    d.cs_n = 1'b0;
                    d.st = ST_CYC;
                end
            end
            ST_CYC:
            begin
                if (q.ph == PH_LAST)
                begin
                    // undriven bus reads as zero
                    if (q.rw)
                    begin
                        d.rdata = bus.dbus_oe_n ? 8'h00 : bus.dbus_d2h;
                    end
                    d.cs_n = 1'b1;
                    d.done = 1'b1;
                    d.st = ST_IDLE;
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase

        // external address switching in front of the display memory
        if (I_TRANSPARENT)
        begin
            d.mem_addr = bus.display_address_lines; // R5
        end
        else if (I_INTERLEAVE)
        begin
            d.mem_addr = q.ph[1] ? I_MPU_ADDR : bus.display_address_lines; // R7
        end
        else
        begin
            d.mem_addr = I_MPU_ACC ? I_MPU_ADDR : bus.display_address_lines; // R6
        end

        // hold latch keeps write data until the update slot comes
        d.mem_we = bus.ra[4] && q.hold_full && I_TRANSPARENT; // R13
        if (I_HOLD_LOAD)
        begin
            d.hold = I_HOLD_DATA; // R13
        end
        d.hold_full = I_HOLD_LOAD || (q.hold_full && !d.mem_we);
    end

    // state register
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.cs_n <= 1'b1;
            q.rw <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end
endmodule : vra_host

// >>> vra_assertions.sv
`timescale 1ns/100ps
module vra_assertions
    import vra_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic e,
    input wire logic cs_n,
    input wire logic rs,
    input wire logic rw,
    input wire logic [7:0] dbus_h2d,
    input wire logic [7:0] dbus_d2h,
    input wire logic dbus_oe_n,
    input wire logic [13:0] display_address_lines,
    input wire logic [4:0] ra,
    input wire logic hsync,
    input wire logic vsync,
    input wire logic de
);
    logic e_q; // e one cycle back
    logic wr_stb; // write lands on first e-high cycle
    logic [4:0] idx_q; // shadow of the selected index
    logic [7:0] mode_q; // shadow of the mode bits
    logic [13:0] upd_q; // shadow of the update address
    assign wr_stb = e && !e_q && !cs_n && !rw;
    // shadows rebuilt from bus writes, since the checker cannot see inside
    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            e_q <= 1'b0;
            idx_q <= 5'h00;
            mode_q <= 8'h00;
            upd_q <= 14'h0000;
        end
        else
        begin
            e_q <= e;
            if (wr_stb && !rs) idx_q <= dbus_h2d[4:0];
            if (wr_stb && rs && idx_q == REG_MODE) mode_q <= dbus_h2d;
            if (wr_stb && rs && idx_q == REG_UPD_HI) upd_q[13:8] <= dbus_h2d[5:0];
            if (wr_stb && rs && idx_q == REG_UPD_LO) upd_q[7:0] <= dbus_h2d;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    deselect_quiet_a: assert property (cs_n |-> dbus_oe_n)
        else $error("data bus driven while deselected");
    status_drive_a: assert property (!cs_n && !rs && rw && e |-> !dbus_oe_n)
        else $error("status read left bus undriven");
    unused_zero_a: assert property (!cs_n && !rs && rw && e && $past(e)
        |-> (dbus_d2h & 8'hdf) == 8'h00) else $error("unused status bit not zero");
    vblank_flag_a: assert property (!cs_n && !rs && rw && e && $past(e) && vsync
        |-> dbus_d2h[STAT_VBLANK]) else $error("blanking flag low in vertical sync");
    pulse_blank_a: assert property (mode_q[3] && mode_q[7] && ra[4] |-> !de)
        else $error("update shown during active display");
    pulse_addr_a: assert property (mode_q[3] && mode_q[7] && ra[4]
        |-> display_address_lines == upd_q) else $error("pulse without update address");
    pulse_single_a: assert property (mode_q[3] && ra[4] |=> !ra[4])
        else $error("update pulse longer than one clock");
    phase2_addr_a: assert property (mode_q[3] && !mode_q[7] && $past(e) && $stable(upd_q)
        && $stable(mode_q) |-> display_address_lines == upd_q)
        else $error("phase 2 address is not the update address");
    vsync_plain_a: assert property ($rose(vsync) && !mode_q[0] |-> ##48 $rose(hsync))
        else $error("vertical sync misplaced in plain scan");
    vsync_half_a: assert property ($rose(vsync) && mode_q[0]
        |-> (##17 $rose(hsync)) or (##48 $rose(hsync))) else $error("bad field sync offset");
endmodule : vra_assertions

// >>> video_ram_address_and_interlace_test.sv
`timescale 1ns/100ps
module video_ram_address_and_interlace_test import vra_pkg::*;;
    logic I_CLK = 1'b0; // 10 MHz character clock
    logic I_ARST_N = 1'b0; // held low for 20 cycles
    logic req = 1'b0, wr = 1'b0, rs = 1'b0, trn = 1'b0, ilv = 1'b0, acc = 1'b0, hld = 1'b0;
    logic [7:0] wd = 8'h00, hd = 8'h00, rdata, mdata;
    logic [13:0] maddr = 14'h2abc, mem_addr;
    logic ready, done, mwe, oe_seen;
    int fail_count = 0, check_count = 0, n, d1, d2;
    vra_if bus ();
    always #50 I_CLK = ~I_CLK;
    vra_dev i_vra_dev (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .bus(bus));
    vra_host i_vra_host (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .bus(bus), .I_REQ(req),
        .I_WR(wr), .I_RS(rs), .I_WDATA(wd), .O_READY(ready), .O_RDATA(rdata), .O_DONE(done),
        .I_TRANSPARENT(trn), .I_INTERLEAVE(ilv), .I_MPU_ACC(acc), .I_MPU_ADDR(maddr),
        .I_HOLD_LOAD(hld), .I_HOLD_DATA(hd), .O_MEM_ADDR(mem_addr), .O_MEM_DATA(mdata),
        .O_MEM_WE(mwe));
    vra_assertions i_vra_assertions (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .e(bus.e),
        .cs_n(bus.cs_n), .rs(bus.rs), .rw(bus.rw), .dbus_h2d(bus.dbus_h2d),
        .dbus_d2h(bus.dbus_d2h), .dbus_oe_n(bus.dbus_oe_n), .ra(bus.ra),
        .display_address_lines(bus.display_address_lines), .hsync(bus.hsync),
        .vsync(bus.vsync), .de(bus.de));
    // remember any cycle in which the device drove the data bus
    always @(posedge I_CLK)
        if (bus.dbus_oe_n === 1'b0) oe_seen = 1'b1;
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task chk(input logic [13:0] got, input logic [13:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one host bus cycle; the user side waits for the done pulse
    task hacc(input logic w, input logic r, input logic [7:0] d);
        int k;
        @(posedge I_CLK);
        req <= 1'b1;
        wr <= w;
        rs <= r;
        wd <= d;
        @(posedge I_CLK);
        req <= 1'b0;
        #1 chk({13'h0, ready}, 14'h0);
        k = 0;
        do
        begin
            @(posedge I_CLK);
            #1 k++;
        end
        while (done !== 1'b1 && k < 20);
        chk({13'h0, done}, 14'h1);
    endtask : hacc
    // index first, then data, as the bus pairs them
    task wreg(input logic [4:0] i, input logic [7:0] d);
        hacc(1'b1, 1'b0, {3'h0, i});
        hacc(1'b1, 1'b1, d);
    endtask : wreg
    task rreg(input logic [4:0] i);
        hacc(1'b1, 1'b0, {3'h0, i});
        hacc(1'b0, 1'b1, 8'h00);
    endtask : rreg
    function automatic logic pick(input int s);
        case (s)
            0: return bus.vsync;
            1: return bus.hsync;
            2: return bus.de;
            3: return mwe;
            default: return bus.e;
        endcase
    endfunction : pick
    // cycles until the chosen signal rises; bounded so a dead video path fails
    task rise(input int s, output int c);
        logic prv;
        logic cur;
        cur = pick(s);
        c = 0;
        do
        begin
            prv = cur;
            @(posedge I_CLK);
            #1 cur = pick(s);
            c++;
        end
        while (!(cur === 1'b1 && prv === 1'b0) && c < 5000);
        if (c >= 5000) chk(14'h0, 14'h1);
    endtask : rise
    // frame start, linear count, and the start of the next character row
    task rowstep(input int lines, input logic [13:0] step);
        rise(0, n);
        rise(2, n);
        chk(bus.display_address_lines, 14'h0010);
        @(posedge I_CLK);
        #1 chk(bus.display_address_lines, 14'h0011);
        repeat (lines) rise(2, n);
        chk(bus.display_address_lines, 14'h0010 + step);
    endtask : rowstep
    // sync-to-hsync distance in two fields running
    task fields;
        rise(0, n);
        rise(1, d1);
        rise(0, n);
        rise(1, d2);
    endtask : fields
    initial
    begin
        repeat (20) @(posedge I_CLK);
        I_ARST_N <= 1'b1;
        // short field: 8 rows of 4 lines keeps each wait near 2000 cycles
        wreg(REG_VTOTAL, 8'h07);
        wreg(REG_VDISP, 8'h03);
        wreg(REG_VSPOS, 8'h05);
        wreg(REG_MAXSL, 8'h03);
        wreg(REG_START_HI, 8'h00);
        wreg(REG_START_LO, 8'h10);
        rreg(REG_HTOTAL);
        chk({6'h0, rdata}, 14'h0000);
        rreg(5'h05);
        chk({6'h0, rdata}, 14'h0000);
        oe_seen = 1'b0;
        rreg(REG_DUMMY);
        chk({13'h0, oe_seen}, 14'h0);
        rise(2, n);
        hacc(1'b0, 1'b0, 8'h00);
        chk({13'h0, oe_seen}, 14'h1);
        chk({6'h0, rdata}, 14'h0000);
        rise(0, n);
        hacc(1'b0, 1'b0, 8'h00);
        chk({6'h0, rdata}, 14'h0020);
        fields;
        chk(d1[13:0], 14'd48);
        chk(d2[13:0], 14'd48);
        rowstep(4, 14'd40);
        wreg(REG_MODE, 8'h04);
        rowstep(4, ROWCOL_STEP);
        wreg(REG_MODE, 8'h01);
        fields;
        chk(14'(d1 + d2), 14'd65);
        chk({13'h0, d1 != d2}, 14'h1);
        wreg(REG_MODE, 8'h03);
        rowstep(2, 14'd40);
        wreg(REG_MODE, 8'h00);
        // shared memory: host address wins while it asks; interleaved, it wins only in phase 2
        @(posedge I_CLK);
        acc <= 1'b1;
        repeat (2) @(posedge I_CLK);
        #1 chk(mem_addr, 14'h2abc);
        @(posedge I_CLK);
        acc <= 1'b0;
        repeat (2) @(posedge I_CLK);
        #1 chk({13'h0, mem_addr != 14'h2abc}, 14'h1);
        @(posedge I_CLK);
        ilv <= 1'b1;
        acc <= 1'b1;
        rise(4, n);
        @(posedge I_CLK);
        #1 chk(mem_addr, 14'h2abc);
        repeat (2) @(posedge I_CLK);
        #1 chk({13'h0, mem_addr != 14'h2abc}, 14'h1);
        @(posedge I_CLK);
        acc <= 1'b0;
        ilv <= 1'b0;
        trn <= 1'b1;
        hld <= 1'b1;
        hd <= 8'h5a;
        @(posedge I_CLK);
        hld <= 1'b0;
        // blanking update: latched byte goes out at the update slot
        wreg(REG_MODE, 8'h88);
        wreg(REG_UPD_HI, 8'h00);
        wreg(REG_UPD_LO, 8'h77);
        rise(3, n);
        chk(mem_addr, 14'h0077);
        chk({6'h0, mdata}, 14'h005a);
        // transparent interleave: update address rides phase 2 only
        wreg(REG_MODE, 8'h08);
        wreg(REG_UPD_HI, 8'h12);
        wreg(REG_UPD_LO, 8'h34);
        rise(4, n);
        @(posedge I_CLK);
        #1 chk(bus.display_address_lines, 14'h1234);
        repeat (2) @(posedge I_CLK);
        #1 chk({13'h0, bus.display_address_lines != 14'h1234}, 14'h1);
        print_verdict;
    end
    // watchdog sized well above the eight field waits above
    initial
    begin
        repeat (80000) @(posedge I_CLK);
        fail_count++;
        print_verdict;
    end
endmodule : video_ram_address_and_interlace_test
